// ==== design/cctg_top.sv ====
// Card cycle timing generator with APB register access
// Summary of operation
// - Timing comes from window wait-state settings; unlisted timing sets use the alternate count registers
// - Intervals counted in host clock periods
// - Intervals never shorter than reference timings
// - Setup: I/O 3, memory 2 or 4
// - 8-bit strobe: 19, 23, zero-wait 7
// - 16-bit I/O strobe: 7 or 11
// - 16-bit memory strobe: 9/13/17/23, zero-wait 5
// - Hold: I/O 2, memory 2 or 3
// - Setup interval adds two host clocks
// - Hold interval adds one host clock
//
// Design decisions made here: the APB register port and the register offsets.
module cctg_top (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Card side
  output logic             o_card_addr_valid,
  output logic             o_card_cmd_n,
  output logic             o_cycle_done
);
  import cctg_pkg::*;

  logic [5:0]  mem_win_r;
  logic [5:0]  io_win_r;
  logic        is_io_r;
  logic        wide_r;
  logic [4:0]  alt_su_r;
  logic [4:0]  alt_ac_r;
  logic [4:0]  alt_hd_r;
  logic [4:0]  su_cnt;
  logic [4:0]  ac_cnt;
  logic [4:0]  hd_cnt;
  logic [4:0]  load_val;
  logic        load;
  logic        last;
  logic        wr_en;
  logic        rd_en;
  logic        start;
  logic        hit;
  logic [31:0] rd_mux;
  logic [5:0]  win_sel;
  logic        io_eff;
  logic        wide_eff;
  cctg_state_t state_r;
  cctg_state_t state_nxt;

  // APB: zero wait states, error on unmapped address
  assign o_pready = 1'b1;
  assign wr_en    = i_psel && i_penable && i_pwrite;
  assign rd_en    = i_psel && !i_pwrite;

  always_comb begin
    hit    = 1'b1;
    rd_mux = '0;
    if (i_paddr == ADDR_MEM_WIN)
      rd_mux[5:0] = mem_win_r;
    else if (i_paddr == ADDR_IO_WIN)
      rd_mux[5:0] = io_win_r;
    else if (i_paddr == ADDR_CTRL) begin
      rd_mux[CTRL_IO_BIT]  = is_io_r;
      rd_mux[CTRL_W16_BIT] = wide_r;
    end else if (i_paddr == ADDR_STATUS) begin
      rd_mux[STAT_BUSY_BIT] = (state_r != CCTG_IDLE);
      rd_mux[STAT_ADDR_BIT] = o_card_addr_valid;
      rd_mux[STAT_CMD_BIT]  = !o_card_cmd_n;
    end else if (i_paddr == ADDR_SETUP)
      rd_mux[4:0] = alt_su_r;
    else if (i_paddr == ADDR_ACTIVE)
      rd_mux[4:0] = alt_ac_r;
    else if (i_paddr == ADDR_HOLD)
      rd_mux[4:0] = alt_hd_r;
    else
      hit = 1'b0;
  end

  assign o_pslverr = i_psel && i_penable && !hit;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst)
      o_prdata <= '0;
    else if (rd_en && !i_penable)
      o_prdata <= rd_mux;
  end

  // Window registers hold the wait-state settings
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mem_win_r <= WIN_RST;
      io_win_r  <= WIN_RST;
    end else if (wr_en && i_paddr == ADDR_MEM_WIN)
      mem_win_r <= i_pwdata[5:0];
    else if (wr_en && i_paddr == ADDR_IO_WIN)
      io_win_r <= i_pwdata[5:0];
  end

  // Alternate counts for unlisted timing sets
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      alt_su_r <= ALT_SU_RST;
      alt_ac_r <= ALT_AC_RST;
      alt_hd_r <= ALT_HD_RST;
    end else if (wr_en && i_paddr == ADDR_SETUP)
      alt_su_r <= i_pwdata[4:0];
    else if (wr_en && i_paddr == ADDR_ACTIVE)
      alt_ac_r <= i_pwdata[4:0];
    else if (wr_en && i_paddr == ADDR_HOLD)
      alt_hd_r <= i_pwdata[4:0];
  end

  // Cycle type latched on any control write while idle
  assign start = wr_en && (i_paddr == ADDR_CTRL) && i_pwdata[CTRL_START_BIT]
                 && (state_r == CCTG_IDLE);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      is_io_r <= 1'b0;
      wide_r  <= 1'b0;
    end else if (wr_en && i_paddr == ADDR_CTRL && state_r == CCTG_IDLE) begin
      is_io_r <= i_pwdata[CTRL_IO_BIT];
      wide_r  <= i_pwdata[CTRL_W16_BIT];
    end
  end

  // Start edge takes its counts from the type being written, not the last one
  assign io_eff   = start ? i_pwdata[CTRL_IO_BIT] : is_io_r;
  assign wide_eff = start ? i_pwdata[CTRL_W16_BIT] : wide_r;
  assign win_sel  = io_eff ? io_win_r : mem_win_r;

  cctg_count_sel u_sel (
    .i_win    (win_sel),
    .i_is_io  (io_eff),
    .i_wide   (wide_eff),
    .i_alt_su (alt_su_r),
    .i_alt_ac (alt_ac_r),
    .i_alt_hd (alt_hd_r),
    .o_su     (su_cnt),
    .o_ac     (ac_cnt),
    .o_hd     (hd_cnt)
  );

  cctg_down_cnt u_cnt (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_load    (load),
    .i_value   (load_val),
    .o_last    (last)
  );

  // Sequencer: setup, strobe active, hold
  always_comb begin
    state_nxt = state_r;
    load      = 1'b0;
    load_val  = '0;
    case (state_r)
      CCTG_IDLE: begin
        if (start) begin
          state_nxt = CCTG_SETUP;
          load      = 1'b1;
          load_val  = su_cnt + SU_EXTRA;
        end
      end
      CCTG_SETUP: begin
        if (last) begin
          state_nxt = CCTG_ACTIVE;
          load      = 1'b1;
          load_val  = ac_cnt;
        end
      end
      CCTG_ACTIVE: begin
        if (last) begin
          state_nxt = CCTG_HOLD;
          load      = 1'b1;
          load_val  = hd_cnt + HD_EXTRA;
        end
      end
      default: begin
        if (last)
          state_nxt = CCTG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst)
      state_r <= CCTG_IDLE;
    else
      state_r <= state_nxt;
  end

  // Address valid and strobe registered from the next state, done from the current state and last
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_card_addr_valid <= 1'b0;
      o_card_cmd_n      <= 1'b1;
      o_cycle_done      <= 1'b0;
    end else begin
      o_card_addr_valid <= (state_nxt != CCTG_IDLE);
      o_card_cmd_n      <= (state_nxt != CCTG_ACTIVE);
      o_cycle_done      <= (state_r == CCTG_HOLD) && last;
    end
  end
endmodule

// ==== design/cctg_pkg.sv ====
// Package: constants and types for the card cycle timing generator
package cctg_pkg;
  // APB register offsets
  localparam logic [7:0] ADDR_MEM_WIN = 8'h00;
  localparam logic [7:0] ADDR_IO_WIN  = 8'h04;
  localparam logic [7:0] ADDR_CTRL    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_SETUP   = 8'h10;
  localparam logic [7:0] ADDR_ACTIVE  = 8'h14;
  localparam logic [7:0] ADDR_HOLD    = 8'h18;
  // Window register fields
  localparam int WS_LO_BIT  = 0;
  localparam int WS_HI_BIT  = 1;
  localparam int ZWS_BIT    = 2;
  localparam int TS_LO_BIT  = 4;
  localparam int TS_HI_BIT  = 5;
  localparam logic [1:0] TS_LISTED = 2'h1;
  localparam logic [5:0] WIN_RST   = 6'h10;
  // Control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_IO_BIT    = 1;
  localparam int CTRL_W16_BIT   = 2;
  // Status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_ADDR_BIT  = 1;
  localparam int STAT_CMD_BIT   = 2;
  // Host clock counts
  localparam logic [4:0] SU_IO      = 5'h03;
  localparam logic [4:0] SU_MEM_LO  = 5'h02;
  localparam logic [4:0] SU_MEM_HI  = 5'h04;
  localparam logic [4:0] HD_IO      = 5'h02;
  localparam logic [4:0] HD_MEM_LO  = 5'h02;
  localparam logic [4:0] HD_MEM_HI  = 5'h03;
  localparam logic [4:0] A8_NOWAIT  = 5'h13;
  localparam logic [4:0] A8_WAIT    = 5'h17;
  localparam logic [4:0] A8_ZERO    = 5'h07;
  localparam logic [4:0] A16_IO_LO  = 5'h07;
  localparam logic [4:0] A16_IO_HI  = 5'h0B;
  localparam logic [4:0] A16_M0     = 5'h09;
  localparam logic [4:0] A16_M1     = 5'h0D;
  localparam logic [4:0] A16_M2     = 5'h11;
  localparam logic [4:0] A16_M3     = 5'h17;
  localparam logic [4:0] A16_MZERO  = 5'h05;
  localparam logic [4:0] SU_EXTRA   = 5'h02;
  localparam logic [4:0] HD_EXTRA   = 5'h01;
  localparam logic [4:0] CNT_ONE    = 5'h01;
  // Default counts for unlisted timing sets
  localparam logic [4:0] ALT_SU_RST = 5'h04;
  localparam logic [4:0] ALT_AC_RST = 5'h17;
  localparam logic [4:0] ALT_HD_RST = 5'h03;

  typedef enum logic [1:0] {
    CCTG_IDLE   = 2'b00,
    CCTG_SETUP  = 2'b01,
    CCTG_ACTIVE = 2'b10,
    CCTG_HOLD   = 2'b11
  } cctg_state_t;
endpackage

// ==== design/cctg_count_sel.sv ====
// Count selection from window wait-state settings
module cctg_count_sel (
  // Window settings
  input  wire logic [5:0] i_win,
  input  wire logic       i_is_io,
  input  wire logic       i_wide,
  // Alternate counts
  input  wire logic [4:0] i_alt_su,
  input  wire logic [4:0] i_alt_ac,
  input  wire logic [4:0] i_alt_hd,
  // Counts
  output logic      [4:0] o_su,
  output logic      [4:0] o_ac,
  output logic      [4:0] o_hd
);
  import cctg_pkg::*;
  logic [1:0] ws;
  logic       zws;
  logic       listed;
  assign ws     = {i_win[WS_HI_BIT], i_win[WS_LO_BIT]};
  assign zws    = i_win[ZWS_BIT];
  assign listed = ({i_win[TS_HI_BIT], i_win[TS_LO_BIT]} == TS_LISTED);

  always_comb begin
    o_su = i_alt_su;
    o_ac = i_alt_ac;
    o_hd = i_alt_hd;
    if (listed) begin
      // I/O uses only the low wait-state bit
      if (i_is_io) begin
        o_su = SU_IO;
        o_hd = HD_IO;
      end else begin
        o_su = ws[1] ? SU_MEM_HI : SU_MEM_LO;
        o_hd = ws[1] ? HD_MEM_HI : HD_MEM_LO;
      end
      if (!i_wide) begin
        if ((i_is_io ? ws[0] : (ws != 2'b00)))
          o_ac = A8_WAIT;
        else if (zws)
          o_ac = A8_ZERO;
        else
          o_ac = A8_NOWAIT;
      end else if (i_is_io) begin
        o_ac = ws[0] ? A16_IO_HI : A16_IO_LO;
      end else begin
        case (ws)
          2'b00:   o_ac = zws ? A16_MZERO : A16_M0;
          2'b01:   o_ac = A16_M1;
          2'b10:   o_ac = A16_M2;
          default: o_ac = A16_M3;
        endcase
      end
    end
  end
endmodule

// ==== design/cctg_down_cnt.sv ====
// Loadable down counter marking the last cycle of an interval
module cctg_down_cnt (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Control
  input  wire logic       i_load,
  input  wire logic [4:0] i_value,
  // Status
  output logic            o_last
);
  import cctg_pkg::*;
  logic [4:0] cnt_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst)
      cnt_r <= '0;
    else if (i_load)
      cnt_r <= i_value;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - CNT_ONE;
  end
  assign o_last = (cnt_r == CNT_ONE) || (cnt_r == '0);
endmodule

// ==== tb/cctg_checker.sv ====
// Timing assertions on the card strobe outputs
module cctg_checker (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic o_card_addr_valid,
  input wire logic o_card_cmd_n,
  input wire logic o_cycle_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  a_cmd_in_addr: assert property (
    !o_card_cmd_n |-> o_card_addr_valid) else $error("strobe outside address");
  a_setup_min: assert property (
    $rose(o_card_addr_valid) |-> o_card_cmd_n[*4]) else $error("setup too short");
  a_strobe_setup: assert property (
    $fell(o_card_cmd_n) |-> $past(o_card_addr_valid, 4)) else $error("setup gap");
  a_active_min: assert property (
    $fell(o_card_cmd_n) |-> !o_card_cmd_n[*5]) else $error("strobe too short");
  a_active_max: assert property (
    $fell(o_card_cmd_n) |-> ##[1:23] o_card_cmd_n) else $error("strobe too long");
  a_hold_min: assert property (
    $rose(o_card_cmd_n) |-> o_card_addr_valid[*3]) else $error("hold too short");
  a_hold_max: assert property (
    $rose(o_card_cmd_n) |-> ##[3:4] !o_card_addr_valid) else $error("hold too long");
  a_done_pulse: assert property (
    $fell(o_card_addr_valid) |-> o_cycle_done ##1 !o_cycle_done) else $error("no done");
endmodule

// ==== tb/cctg_card_model.sv ====
// Card-side monitor measuring setup, strobe and hold lengths
module cctg_card_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // Card pins
  input  wire logic       i_addr_valid,
  input  wire logic       i_cmd_n,
  // Measured cycle
  output logic      [5:0] o_setup,
  output logic      [5:0] o_active,
  output logic      [5:0] o_hold,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] s_r;
  logic [5:0] a_r;
  logic [5:0] h_r;
  always_ff @(posedge i_clk) begin
    o_ready <= 1'b0;
    if (i_srst) begin
      s_r <= 6'h00;
      a_r <= 6'h00;
      h_r <= 6'h00;
    end else if (i_addr_valid && i_cmd_n && a_r == 6'h00) begin
      s_r <= s_r + 6'h01;
    end else if (!i_cmd_n) begin
      a_r <= a_r + 6'h01;
    end else if (i_addr_valid) begin
      h_r <= h_r + 6'h01;
    end else if (s_r != 6'h00) begin
      o_setup <= s_r;
      o_active <= a_r;
      o_hold <= h_r;
      o_ready <= 1'b1;
      s_r <= 6'h00;
      a_r <= 6'h00;
      h_r <= 6'h00;
    end
  end
endmodule

// ==== tb/card_cycle_timing_gen_test.sv ====
// Self-checking bench for the card cycle timing generator
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %h exp %h", $time, g, e); end end
module card_cycle_timing_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0;
  logic        srst = 1;
  logic        psel = 0;
  logic        pen = 0;
  logic        pw = 0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic        pready;
  logic        err;
  logic        perr;
  logic        av;
  logic        cn;
  logic        rdy;
  logic [5:0]  ms;
  logic [5:0]  ma;
  logic [5:0]  mh;
  int          n_fail = 0;
  int          comparisons = 0;
  int          seed = 77078;
  int          s;
  int          a;
  int          h;
  int          su;
  always #4 clk = ~clk;
  cctg_top dut (.i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .o_card_addr_valid(av), .o_card_cmd_n(cn), .o_cycle_done());
  cctg_card_model card (.i_clk(clk), .i_srst(srst), .i_addr_valid(av), .i_cmd_n(cn),
    .o_setup(ms), .o_active(ma), .o_hold(mh), .o_ready(rdy));
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input bit w, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pw <= w;
    pa <= ad;
    pwd <= d;
    @(posedge clk) pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  function void model(bit io, bit wd, bit [1:0] ws, bit z);
    s = (io ? 3 : ws[1] ? 4 : 2) + 2;
    h = (io ? 2 : ws[1] ? 3 : 2) + 1;
    if (!wd) a = (io ? ws[0] : ws != 0) ? 23 : z ? 7 : 19;
    else if (io) a = ws[0] ? 11 : 7;
    else a = ws == 0 ? (z ? 5 : 9) : ws == 1 ? 13 : ws == 2 ? 17 : 23;
  endfunction
  task cyc(input bit io, input bit wd, input logic [31:0] win);
    int k;
    apb(1'b1, io ? 8'h04 : 8'h00, win);
    apb(1'b1, 8'h08, {29'h0, wd, io, 1'b1});
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(rd[2:0], 3'h3)
    apb(1'b1, 8'h08, {29'h0, ~wd, ~io, 1'b1});
    k = 0;
    while (rdy !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k >= 100) n_fail++;
    `CHK(ms, s[5:0])
    `CHK(ma, a[5:0])
    `CHK(mh, h[5:0])
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h10)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h17)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    for (int i = 0; i < 32; i++) begin
      model(i[0], i[1], i[3:2], i[4]);
      cyc(i[0], i[1], $random(seed) & 32'hFFFFFFC0 | 32'h10 | i[4:2]);
    end
    repeat (3) begin
      su = 2 + {$random(seed)} % 3;
      a = 5 + {$random(seed)} % 19;
      h = 3 + {$random(seed)} % 2;
      s = su + 2;
      apb(1'b1, 8'h10, su);
      apb(1'b1, 8'h14, a);
      apb(1'b1, 8'h18, h - 1);
      cyc(1'b0, 1'b1, 32'h0);
    end
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict;
  end
endmodule
bind cctg_top cctg_checker chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .o_card_addr_valid(o_card_addr_valid), .o_card_cmd_n(o_card_cmd_n),
  .o_cycle_done(o_cycle_done));
